// file: rtl/pif_pkg.sv
// Constants for the peripheral interrupt flag block
// What this block does
// - Flags set on their events regardless of any enable or global enable.
// - Bit 7 sets on each host port read or write, sticky until cleared.
// - Bit 6 sets when a conversion finishes; zero while incomplete.
// - Bit 5 read-only, mirrors receive buffer full.
// - Bit 4 read-only, mirrors transmit buffer empty.
// - Bit 3 sets on each completed serial transfer in SPI or I2C slave.
// - In I2C master, bit 3 also sets on finished start/stop/restart/ack sequences.
// - In I2C master or I2C slave, bit 3 sets on bus start/stop while port idle.
// - Capture mode: bit 2 sets on timer-1 capture, sticky.
// - Compare mode: bit 2 sets on compare match; unused in pulse-width mode.
package pif_pkg;
	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam logic [3:0] PIF_ADDR_FLAGS = 4'h0;
	localparam logic [3:0] PIF_ADDR_STATUS = 4'h4;
	localparam logic [3:0] PIF_ADDR_MASK = 4'h8;
	localparam logic [3:0] PIF_ADDR_MODE = 4'hc;
	// ----------------------------------------
	// Field positions and values
	// ----------------------------------------
	localparam int PIF_BIT_HOST = 7;
	localparam int PIF_BIT_CONV = 6;
	localparam int PIF_BIT_RX = 5;
	localparam int PIF_BIT_TX = 4;
	localparam int PIF_BIT_SSP = 3;
	localparam int PIF_BIT_CCP = 2;
	localparam int PIF_BIT_TMR2 = 1;
	localparam int PIF_BIT_TIMER_ONE_COUNT = 0;
	localparam logic [7:0] PIF_RW_MASK = 8'hcf;
	localparam logic [7:0] PIF_FLAGS_RESET = 8'h00;
	localparam logic [7:0] PIF_MASK_RESET = 8'h00;
	localparam logic [1:0] PIF_MODE_RESET = 2'h0;
	localparam logic [31:0] PIF_UNMAPPED_DATA = 32'h0000_0000;
	// Capture/compare unit mode field
	typedef enum logic [1:0] {
		PIF_CCP_OFF = 2'h0,
		PIF_CCP_CAPTURE = 2'h1,
		PIF_CCP_COMPARE = 2'h2,
		PIF_CCP_PWM = 2'h3
	} pif_ccp_mode_t;
endpackage

// file: rtl/pif_ssp_events.sv
// Merges the synchronous serial port event sources into one set pulse
module pif_ssp_events
	import pif_pkg::*;
(
	// Serial port mode
	input wire logic spi_mode_in,
	input wire logic i2c_slave_mode_in,
	input wire logic i2c_master_mode_in,
	input wire logic port_idle_in,
	// Events
	input wire logic xfer_done_in,
	input wire logic seq_done_in,
	input wire logic bus_start_in,
	input wire logic bus_stop_in,
	// Result
	output logic set_out
);
	always_comb begin
		set_out = 1'b0;
		if ((spi_mode_in || i2c_slave_mode_in || i2c_master_mode_in) && xfer_done_in) begin
			set_out = 1'b1;
		end
		if (i2c_master_mode_in && seq_done_in) begin
			set_out = 1'b1;
		end
		if ((i2c_master_mode_in || i2c_slave_mode_in) && port_idle_in && (bus_start_in || bus_stop_in)) begin
			set_out = 1'b1;
		end
	end
endmodule

// file: rtl/pif_flags.sv
// Peripheral interrupt flag register with Avalon-MM slave and interrupt
module pif_flags
	import pif_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	// Avalon-MM slave
	input wire logic [3:0] avs_address_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_writedata_in,
	input wire logic [3:0] avs_byteenable_in,
	output logic [31:0] avs_readdata_out,
	output logic avs_waitrequest_out,
	// Peripheral events, one-cycle pulses
	input wire logic host_port_access_in,
	input wire logic conversion_done_in,
	input wire logic capcomp_capture_in,
	input wire logic capcomp_match_in,
	input wire logic timer_two_match_in,
	input wire logic timer_one_overflow_in,
	// Serial buffer levels
	input wire logic serial_rx_full_in,
	input wire logic serial_tx_empty_in,
	// Synchronous serial port
	input wire logic ssp_spi_mode_in,
	input wire logic ssp_i2c_slave_mode_in,
	input wire logic ssp_i2c_master_mode_in,
	input wire logic ssp_idle_in,
	input wire logic ssp_xfer_done_in,
	input wire logic ssp_seq_done_in,
	input wire logic ssp_bus_start_in,
	input wire logic ssp_bus_stop_in,
	// Flag and interrupt outputs
	output logic [7:0] peripheral_irq_flags_out,
	output logic irq_out
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [7:0] flags_q;
	logic [7:0] flags_d;
	logic [7:0] status_q;
	logic [7:0] mask_q;
	logic [1:0] mode_q;
	logic ack_q;
	logic [7:0] hw_set;
	logic ssp_set;
	logic access;
	logic wr_take;
	logic rd_take;
	logic byte0;

	function automatic logic [7:0] pif_write_clear(input logic [7:0] cur, input logic [7:0] wdata);
		// Writable bits keep ones written, zeros clear
		pif_write_clear = cur & (wdata | ~PIF_RW_MASK);
	endfunction

	pif_ssp_events u_ssp (
		.spi_mode_in(ssp_spi_mode_in),
		.i2c_slave_mode_in(ssp_i2c_slave_mode_in),
		.i2c_master_mode_in(ssp_i2c_master_mode_in),
		.port_idle_in(ssp_idle_in),
		.xfer_done_in(ssp_xfer_done_in),
		.seq_done_in(ssp_seq_done_in),
		.bus_start_in(ssp_bus_start_in),
		.bus_stop_in(ssp_bus_stop_in),
		.set_out(ssp_set)
	);

	// ----------------------------------------
	// Bus handshake: one wait cycle per access
	// ----------------------------------------
	assign access = (avs_read_in || avs_write_in) && !ack_q;
	assign wr_take = avs_write_in && ack_q;
	assign rd_take = avs_read_in && ack_q;
	assign byte0 = avs_byteenable_in[0];

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= access;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			avs_waitrequest_out <= 1'b1;
		end else begin
			avs_waitrequest_out <= !access;
		end
	end

	// ----------------------------------------
	// Hardware set sources
	// ----------------------------------------
	always_comb begin
		hw_set = 8'h00;
		hw_set[PIF_BIT_HOST] = host_port_access_in;
		hw_set[PIF_BIT_CONV] = conversion_done_in;
		hw_set[PIF_BIT_SSP] = ssp_set;
		hw_set[PIF_BIT_CCP] = (mode_q == PIF_CCP_CAPTURE && capcomp_capture_in) ||
			(mode_q == PIF_CCP_COMPARE && capcomp_match_in);
		hw_set[PIF_BIT_TMR2] = timer_two_match_in;
		hw_set[PIF_BIT_TIMER_ONE_COUNT] = timer_one_overflow_in;
	end

	// ----------------------------------------
	// Flag register
	// ----------------------------------------
	always_comb begin
		flags_d = flags_q;
		if (wr_take && avs_address_in == PIF_ADDR_FLAGS && byte0) begin
			flags_d = pif_write_clear(flags_q, avs_writedata_in[7:0]);
		end
		flags_d = (flags_d | hw_set) & PIF_RW_MASK;
		flags_d[PIF_BIT_RX] = serial_rx_full_in;
		flags_d[PIF_BIT_TX] = serial_tx_empty_in;
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			flags_q <= PIF_FLAGS_RESET;
		end else begin
			flags_q <= flags_d;
		end
	end

	// ----------------------------------------
	// Sticky status, mask and mode
	// ----------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			status_q <= PIF_FLAGS_RESET;
		end else if (rd_take && avs_address_in == PIF_ADDR_STATUS) begin
			// Clear only what the read reported; later events survive
			status_q <= (status_q & ~avs_readdata_out[7:0]) | hw_set;
		end else begin
			status_q <= status_q | hw_set;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			mask_q <= PIF_MASK_RESET;
		end else if (wr_take && avs_address_in == PIF_ADDR_MASK && byte0) begin
			mask_q <= avs_writedata_in[7:0];
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			mode_q <= PIF_MODE_RESET;
		end else if (wr_take && avs_address_in == PIF_ADDR_MODE && byte0) begin
			mode_q <= avs_writedata_in[1:0];
		end
	end

	// ----------------------------------------
	// Read data and outputs
	// ----------------------------------------
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			avs_readdata_out <= PIF_UNMAPPED_DATA;
		end else if (access && avs_read_in) begin
			unique case (avs_address_in)
				PIF_ADDR_FLAGS: avs_readdata_out <= {24'h000000, flags_q};
				PIF_ADDR_STATUS: avs_readdata_out <= {24'h000000, status_q};
				PIF_ADDR_MASK: avs_readdata_out <= {24'h000000, mask_q};
				PIF_ADDR_MODE: avs_readdata_out <= {30'h00000000, mode_q};
				default: avs_readdata_out <= PIF_UNMAPPED_DATA;
			endcase
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			peripheral_irq_flags_out <= PIF_FLAGS_RESET;
			irq_out <= 1'b0;
		end else begin
			peripheral_irq_flags_out <= flags_d;
			irq_out <= |(status_q & mask_q);
		end
	end
endmodule

// file: verification/pif_flags_properties.sv
// Port-level checks for the peripheral flag block
module pif_flags_properties
	import pif_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic avs_read_in,
	input wire logic avs_write_in,
	input wire logic [31:0] avs_readdata_out,
	input wire logic avs_waitrequest_out,
	input wire logic host_port_access_in,
	input wire logic conversion_done_in,
	input wire logic timer_two_match_in,
	input wire logic timer_one_overflow_in,
	input wire logic serial_rx_full_in,
	input wire logic serial_tx_empty_in,
	input wire logic [7:0] peripheral_irq_flags_out
);
	default clocking @(posedge clk_sys_in);
	endclocking
	default disable iff (sys_rst_in);
	sequence s_taken;
		(avs_read_in || avs_write_in) && avs_waitrequest_out;
	endsequence
	sequence s_answer;
		!avs_waitrequest_out ##1 avs_waitrequest_out;
	endsequence
	chk_one_wait_answer: assert property (s_taken |=> s_answer)
		else $error("bus answer late");
	chk_upper_read_zero: assert property (!avs_waitrequest_out && avs_read_in |-> avs_readdata_out[31:8] == 24'h0)
		else $error("upper read bits set");
	chk_host_port_sets: assert property (host_port_access_in |-> ##[0:1] peripheral_irq_flags_out[7])
		else $error("host flag missed");
	chk_conv_done_sets: assert property (conversion_done_in |-> ##[0:1] peripheral_irq_flags_out[6])
		else $error("conversion flag missed");
	chk_timer_two_sets: assert property (timer_two_match_in |-> ##[0:1] peripheral_irq_flags_out[1])
		else $error("timer two flag missed");
	chk_timer_one_sets: assert property (timer_one_overflow_in |-> ##[0:1] peripheral_irq_flags_out[0])
		else $error("timer one flag missed");
	chk_rx_level_mirror: assert property (!$past(sys_rst_in) && $stable(serial_rx_full_in)
		|-> peripheral_irq_flags_out[5] == serial_rx_full_in)
		else $error("receive flag wrong");
	chk_tx_level_mirror: assert property (!$past(sys_rst_in) && $stable(serial_tx_empty_in)
		|-> peripheral_irq_flags_out[4] == serial_tx_empty_in)
		else $error("transmit flag wrong");
endmodule
bind pif_flags pif_flags_properties pif_flags_properties_inst (.clk_sys_in, .sys_rst_in, .avs_read_in,
	.avs_write_in, .avs_readdata_out, .avs_waitrequest_out, .host_port_access_in, .conversion_done_in,
	.timer_two_match_in, .timer_one_overflow_in, .serial_rx_full_in, .serial_tx_empty_in,
	.peripheral_irq_flags_out);

// file: verification/peripheral_irq_flag_register_bench.sv
// Self-checking bench for the peripheral flag block
module peripheral_irq_flag_register_bench
	import pif_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys_in = 0, sys_rst_in = 1, rd = 0, wr = 0, wq, irq;
	logic [3:0] adr = 0;
	logic [31:0] wd = 0, rdo, rdat;
	logic [9:0] p = 0;
	logic [5:0] l = 0;
	logic [8:0] tab [9] = '{9'h111, 9'h091, 9'h051, 9'h049, 9'h108, 9'h065, 9'h063, 9'h044, 9'h010};
	int mismatches = 0, tests_run = 0;
	pif_flags pif_flags_inst (.clk_sys_in, .sys_rst_in, .avs_address_in(adr), .avs_read_in(rd),
		.avs_write_in(wr), .avs_writedata_in(wd), .avs_byteenable_in(4'hf), .avs_readdata_out(rdo),
		.avs_waitrequest_out(wq), .host_port_access_in(p[5]), .conversion_done_in(p[4]),
		.capcomp_capture_in(p[3]), .capcomp_match_in(p[2]), .timer_two_match_in(p[1]),
		.timer_one_overflow_in(p[0]), .serial_rx_full_in(l[5]), .serial_tx_empty_in(l[4]),
		.ssp_spi_mode_in(l[3]), .ssp_i2c_slave_mode_in(l[2]), .ssp_i2c_master_mode_in(l[1]),
		.ssp_idle_in(l[0]), .ssp_xfer_done_in(p[9]), .ssp_seq_done_in(p[8]), .ssp_bus_start_in(p[7]),
		.ssp_bus_stop_in(p[6]), .peripheral_irq_flags_out(), .irq_out(irq));
	always #12.5 clk_sys_in = ~clk_sys_in;
	task automatic close_out;
		if (mismatches == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys_in);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= d;
		n = 0;
		do begin
			@(posedge clk_sys_in);
			n++;
		end while (wq !== 1'b0 && n < 50);
		rdat = rdo;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 50) begin
			chk(0, 1);
			close_out;
		end
	endtask
	task automatic rchk(input logic [3:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		chk(rdat, e);
	endtask
	task automatic pu(input logic [9:0] v);
		@(posedge clk_sys_in);
		p <= v;
		@(posedge clk_sys_in);
		p <= 10'h000;
	endtask
	task automatic t_flags;
		rchk(PIF_ADDR_FLAGS, 32'h0);
		pu(10'h033);
		rchk(PIF_ADDR_FLAGS, 32'hc3);
		bus(1'b1, PIF_ADDR_FLAGS, 32'hff);
		rchk(PIF_ADDR_FLAGS, 32'hc3);
		fork
			bus(1'b1, PIF_ADDR_FLAGS, 32'h0);
			begin
				repeat (2) @(posedge clk_sys_in);
				p <= 10'h020;
				@(posedge clk_sys_in);
				p <= 10'h000;
			end
		join
		rchk(PIF_ADDR_FLAGS, 32'h80);
	endtask
	task automatic t_levels;
		l[5:4] <= 2'b11;
		bus(1'b1, PIF_ADDR_FLAGS, 32'h0);
		rchk(PIF_ADDR_FLAGS, 32'h30);
		l[5:4] <= 2'b01;
		rchk(PIF_ADDR_FLAGS, 32'h10);
		l[5:4] <= 2'b00;
	endtask
	task automatic t_ssp;
		foreach (tab[i]) begin
			l[3:0] <= tab[i][8:5];
			pu({tab[i][4:1], 6'h00});
			rchk(PIF_ADDR_FLAGS, {28'h0, tab[i][0], 3'h0});
			bus(1'b1, PIF_ADDR_FLAGS, 32'h0);
		end
	endtask
	task automatic t_ccp;
		for (int m = 0; m < 4; m++) begin
			bus(1'b1, PIF_ADDR_MODE, 32'(m));
			pu(10'h008);
			rchk(PIF_ADDR_FLAGS, (m == 1) ? 32'h4 : 32'h0);
			bus(1'b1, PIF_ADDR_FLAGS, 32'h0);
			pu(10'h004);
			rchk(PIF_ADDR_FLAGS, (m == 2) ? 32'h4 : 32'h0);
			bus(1'b1, PIF_ADDR_FLAGS, 32'h0);
		end
	endtask
	task automatic t_irq;
		bus(1'b0, PIF_ADDR_STATUS, 32'h0);
		bus(1'b1, PIF_ADDR_MASK, 32'h1);
		pu(10'h001);
		repeat (2) @(posedge clk_sys_in);
		chk(irq, 1);
		rchk(PIF_ADDR_STATUS, 32'h1);
		repeat (2) @(posedge clk_sys_in);
		chk(irq, 0);
		pu(10'h002);
		repeat (2) @(posedge clk_sys_in);
		chk(irq, 0);
		rchk(PIF_ADDR_STATUS, 32'h2);
		bus(1'b1, 4'h2, 32'hff);
		rchk(4'h2, 32'h0);
	endtask
	initial begin
		repeat (6) @(posedge clk_sys_in);
		sys_rst_in <= 1'b0;
		t_flags;
		t_levels;
		t_ssp;
		t_ccp;
		t_irq;
		close_out;
	end
endmodule
